// File: dac_startup_sequencer.sv
// host sequencer that brings the converter up through its serial register port
`timescale 1ns/1ps
`default_nettype none

module dac_startup_sequencer (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // user command and status
    input wire logic START,
    input wire logic ABORT,
    output logic BUSY,
    output logic DONE,
    output logic FAIL,
    output logic [1:0] FAIL_CODE,
    output logic [2:0] STEP,
    output logic [4:0] ENTRY,
    output logic [4:0] LOCK_TRIES,
    output logic [7:0] LOCK_READ,
    // serial register port of the device
    output logic SPI_CS_N,
    output logic SPI_SCLK,
    output logic SPI_SDIO,
    input wire logic SPI_SDO
);
    // ------------------------------------------------------------------
    // serial frame engine
    // ------------------------------------------------------------------
    logic tick;
    logic req_valid;
    startup_pkg::spi_req_t req;
    logic req_ready;
    logic frame_done;
    logic [7:0] frame_rdata;
    logic frame_active;

    tick_divider #(
        .DIV(startup_pkg::SCLK_HALF_CYC)
    ) u_tick (
        .clk(CLK),
        .resetn(RESETN),
        .run(frame_active),
        .tick(tick)
    );

    spi_frame u_frame (
        .clk(CLK),
        .resetn(RESETN),
        .tick(tick),
        .req_valid(req_valid),
        .req(req),
        .req_ready(req_ready),
        .done(frame_done),
        .rdata(frame_rdata),
        .active(frame_active),
        .cs_n(SPI_CS_N),
        .sclk(SPI_SCLK),
        .mosi(SPI_SDIO),
        .miso_pin(SPI_SDO)
    );

    // ------------------------------------------------------------------
    // sequencer state
    // ------------------------------------------------------------------
    startup_pkg::seq_state_t state;
    startup_pkg::seq_state_t next_state;
    logic [4:0] idx;
    logic [4:0] next_idx;
    logic polling;
    logic next_polling;
    logic [4:0] tries;
    logic [4:0] next_tries;
    logic [11:0] wait_cnt;
    logic [11:0] next_wait_cnt;
    logic abort_seen;
    logic next_abort_seen;
    logic [1:0] fail_code;
    logic [1:0] next_fail_code;
    logic [7:0] lock_read;
    logic [7:0] next_lock_read;
    logic lock_ok;

    assign lock_ok = frame_rdata[startup_pkg::LOCK_BIT];

    // request presented only while issuing; the frame engine takes it when idle
    always_comb begin
        req.rd = polling;
        req.addr = polling ? startup_pkg::REG_PLL_LOCK_STATUS : startup_pkg::SEQ[idx].addr;
        req.data = polling ? 8'h00 : startup_pkg::SEQ[idx].data;
        req_valid = (state == startup_pkg::ST_ISSUE);
    end

    always_comb begin
        next_state = state;
        next_idx = idx;
        next_polling = polling;
        next_tries = tries;
        next_wait_cnt = wait_cnt;
        next_abort_seen = abort_seen;
        next_fail_code = fail_code;
        next_lock_read = lock_read;
        // abort is held until the running frame ends, never cut mid-frame
        if (ABORT && state != startup_pkg::ST_IDLE) begin
            next_abort_seen = 1'b1;
        end
        unique case (state)
            startup_pkg::ST_IDLE,
            startup_pkg::ST_DONE,
            startup_pkg::ST_FAIL: begin
                if (START) begin
                    // list opens with soft reset then port setup
                    next_state = startup_pkg::ST_ISSUE;
                    next_idx = 5'h00;
                    next_polling = 1'b0;
                    next_tries = 5'h00;
                    next_abort_seen = 1'b0;
                    next_fail_code = 2'b00;
                    next_lock_read = 8'h00;
                end
            end
            startup_pkg::ST_ISSUE: begin
                if (req_ready) begin
                    next_state = startup_pkg::ST_XFER;
                end
            end
            startup_pkg::ST_XFER: begin
                // wait for the whole frame before anything else moves
                if (frame_done) begin
                    next_state = startup_pkg::ST_GAP;
                    next_wait_cnt = 12'h000;
                    if (polling) begin
                        next_lock_read = frame_rdata;
                        next_tries = tries + 5'h01;
                        if (lock_ok) begin
                            // datapath only after lock is confirmed
                            next_polling = 1'b0;
                            next_idx = idx + 5'h01;
                        end else if (tries == 5'(startup_pkg::POLL_LIMIT - 1)) begin
                            next_state = startup_pkg::ST_FAIL;
                            next_fail_code = 2'b01;
                        end else begin
                            next_state = startup_pkg::ST_POLL_WAIT;
                        end
                    end else if (idx == startup_pkg::LOCK_AFTER_IDX) begin
                        next_polling = 1'b1;
                    end else if (idx == startup_pkg::LAST_IDX) begin
                        next_state = startup_pkg::ST_DONE;
                    end else begin
                        next_idx = idx + 5'h01;
                    end
                end
            end
            startup_pkg::ST_POLL_WAIT: begin
                next_wait_cnt = wait_cnt + 12'h001;
                if (wait_cnt == 12'(startup_pkg::POLL_GAP_CYC - 1)) begin
                    next_state = startup_pkg::ST_GAP;
                    next_wait_cnt = 12'h000;
                end
            end
            startup_pkg::ST_GAP: begin
                // chip select stays high a minimum time between frames
                next_wait_cnt = wait_cnt + 12'h001;
                if (wait_cnt == 12'(startup_pkg::CS_GAP_CYC - 1)) begin
                    next_state = startup_pkg::ST_ISSUE;
                    next_wait_cnt = 12'h000;
                end
            end
            default: begin
                next_state = startup_pkg::ST_IDLE;
            end
        endcase
        if (next_abort_seen && (next_state == startup_pkg::ST_GAP ||
                next_state == startup_pkg::ST_POLL_WAIT)) begin
            next_state = startup_pkg::ST_FAIL;
            next_fail_code = 2'b10;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state <= startup_pkg::ST_IDLE;
            idx <= 5'h00;
            polling <= 1'b0;
            tries <= 5'h00;
            wait_cnt <= 12'h000;
            abort_seen <= 1'b0;
            fail_code <= 2'b00;
            lock_read <= 8'h00;
        end else begin
            state <= next_state;
            idx <= next_idx;
            polling <= next_polling;
            tries <= next_tries;
            wait_cnt <= next_wait_cnt;
            abort_seen <= next_abort_seen;
            fail_code <= next_fail_code;
            lock_read <= next_lock_read;
        end
    end

    // ------------------------------------------------------------------
    // status outputs
    // ------------------------------------------------------------------
    logic busy;
    logic done;
    logic fail;
    logic [2:0] step;
    logic next_busy;
    logic next_done;
    logic next_fail;
    logic [2:0] next_step;

    // step 1 covers port, power, fixed writes and PLL; step 2 the datapath
    always_comb begin
        next_busy = !(next_state == startup_pkg::ST_IDLE ||
            next_state == startup_pkg::ST_DONE ||
            next_state == startup_pkg::ST_FAIL);
        next_done = (next_state == startup_pkg::ST_DONE);
        next_fail = (next_state == startup_pkg::ST_FAIL);
        next_step = 3'h0;
        if (next_busy || next_done) begin
            next_step = (next_idx > startup_pkg::LOCK_AFTER_IDX) ? 3'h2 : 3'h1;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            busy <= 1'b0;
            done <= 1'b0;
            fail <= 1'b0;
            step <= 3'h0;
        end else begin
            busy <= next_busy;
            done <= next_done;
            fail <= next_fail;
            step <= next_step;
        end
    end

    assign BUSY = busy;
    assign DONE = done;
    assign FAIL = fail;
    assign FAIL_CODE = fail_code;
    assign STEP = step;
    assign ENTRY = idx;
    assign LOCK_TRIES = tries;
    assign LOCK_READ = lock_read;
endmodule

`default_nettype wire

// File: dac_startup_sequencer_assertions.sv
// concurrent checks on the start-up host's user and serial ports
`timescale 1ns/1ps
`default_nettype none

module dac_startup_sequencer_assertions (
    // clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // user side
    input wire logic START,
    input wire logic ABORT,
    input wire logic BUSY,
    input wire logic DONE,
    input wire logic FAIL,
    input wire logic [1:0] FAIL_CODE,
    input wire logic [2:0] STEP,
    input wire logic [4:0] ENTRY,
    input wire logic [4:0] LOCK_TRIES,
    input wire logic [7:0] LOCK_READ,
    // serial port
    input wire logic SPI_CS_N,
    input wire logic SPI_SCLK,
    input wire logic SPI_SDIO,
    input wire logic SPI_SDO
);
    // ----
    // frame length counter
    // ----
    logic [8:0] low_cnt;
    logic [8:0] next_low_cnt;

    // counter over the rules' 192 cycles, too long for a repetition
    always_comb begin
        next_low_cnt = (!RESETN || SPI_CS_N) ? 9'h000 : low_cnt + 9'h001;
    end

    always_ff @(posedge CLK) begin
        low_cnt <= next_low_cnt;
    end

    // ----
    // properties
    // ----
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    start_taken_a: assert property (START && !BUSY |=> ##[0:1] BUSY)
        else $error("start not taken");
    first_frame_a: assert property (START && !BUSY |-> ##[1:3] !SPI_CS_N)
        else $error("no frame after start");
    frame_len_a: assert property ($rose(SPI_CS_N) |-> low_cnt == 9'h0c0)
        else $error("frame length wrong");
    frame_gap_a: assert property ($rose(SPI_CS_N) |-> SPI_CS_N [*3])
        else $error("select gap too short");
    sclk_half_a: assert property ($rose(SPI_SCLK) |-> SPI_SCLK [*4] ##1 !SPI_SCLK)
        else $error("serial clock half period wrong");
    sclk_idle_a: assert property (SPI_CS_N |-> !SPI_SCLK)
        else $error("serial clock runs outside frame");
    sdio_hold_a: assert property (SPI_SCLK |-> $stable(SPI_SDIO))
        else $error("data moved while clock high");
    idle_quiet_a: assert property (!BUSY |-> SPI_CS_N && !SPI_SCLK)
        else $error("frame while idle");
    lock_gate_a: assert property (STEP == 3'h2 |-> LOCK_READ[0])
        else $error("datapath step without lock");
    poll_bound_a: assert property (FAIL && FAIL_CODE == 2'h1 |-> LOCK_TRIES == 5'h10)
        else $error("lock failure at wrong try count");
    done_clean_a: assert property ($rose(DONE) |-> !BUSY && !FAIL && LOCK_READ[0])
        else $error("done without clean finish");
endmodule
`default_nettype wire

// File: dac_startup_sequencer_bench.sv
// self-checking bench for the converter start-up host
`timescale 1ns/1ps
`default_nettype none

module dac_startup_sequencer_bench;
    // ----
    // signals
    // ----
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic START = 1'b0;
    logic ABORT = 1'b0;
    logic BUSY, DONE, FAIL, SPI_CS_N, SPI_SCLK, SPI_SDIO, SPI_SDO;
    logic [1:0] FAIL_CODE;
    logic [2:0] STEP;
    logic [4:0] ENTRY, LOCK_TRIES;
    logic [7:0] LOCK_READ;
    logic [23:0] tbl [32];
    int n_mismatch = 0;
    int total_checks = 0;
    int i;

    always #20 CLK = ~CLK;

    dac_startup_sequencer uut (.CLK(CLK), .RESETN(RESETN), .START(START), .ABORT(ABORT),
        .BUSY(BUSY), .DONE(DONE), .FAIL(FAIL), .FAIL_CODE(FAIL_CODE), .STEP(STEP),
        .ENTRY(ENTRY), .LOCK_TRIES(LOCK_TRIES), .LOCK_READ(LOCK_READ), .SPI_CS_N(SPI_CS_N),
        .SPI_SCLK(SPI_SCLK), .SPI_SDIO(SPI_SDIO), .SPI_SDO(SPI_SDO));
    spi_device_model dev (.cs_n(SPI_CS_N), .sclk(SPI_SCLK), .sdio(SPI_SDIO), .sdo(SPI_SDO));

    // ----
    // helpers
    // ----
    task automatic chk_frame(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: frame %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: status %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    function automatic logic [23:0] read_frame(input int k, input int lk);
        return {1'b1, 15'h0084, 7'h00, k == lk};
    endfunction

    task automatic pulse_start;
        @(negedge CLK);
        START = 1'b1;
        @(negedge CLK);
        START = 1'b0;
    endtask

    // bounded wait; the flag may take an edge to rise first
    task automatic wait_idle(input int lim);
        int k;
        repeat (2) @(negedge CLK);
        for (k = 0; k < lim && BUSY !== 1'b0; k++) @(negedge CLK);
        chk_val({7'h00, BUSY}, 8'h00);
    endtask

    // ----
    // tests
    // ----
    task automatic run_seq(input int lk);
        int nr;
        int j;
        nr = (lk < 16) ? lk + 1 : 16;
        dev.log_q.delete();
        dev.n_reads = 0;
        dev.lock_after = lk;
        pulse_start();
        repeat ($urandom_range(2000, 50)) @(negedge CLK);
        pulse_start();
        wait_idle(60000);
        for (j = 0; j < 30; j++) chk_frame(dev.log_q[j], tbl[j]);
        for (j = 0; j < nr; j++) chk_frame(dev.log_q[30 + j], read_frame(j, lk));
        if (lk < 16) begin
            chk_frame(dev.log_q[30 + nr], tbl[30]);
            chk_frame(dev.log_q[31 + nr], tbl[31]);
        end
        chk_val(8'(dev.log_q.size()), (lk < 16) ? 8'(nr + 32) : 8'(nr + 30));
        chk_val({4'h0, DONE, FAIL, FAIL_CODE}, (lk < 16) ? 8'h08 : 8'h05);
        chk_val({3'h0, LOCK_TRIES}, 8'(nr));
        chk_val({STEP, ENTRY}, (lk < 16) ? 8'h5f : 8'h1d);
        chk_val(LOCK_READ, (lk < 16) ? 8'h01 : 8'h00);
        $display("sequence with lock after %0d reads done", lk);
    endtask

    task automatic abort_test;
        int n;
        int j;
        dev.log_q.delete();
        pulse_start();
        repeat ($urandom_range(1500, 300)) @(negedge CLK);
        ABORT = 1'b1;
        @(negedge CLK);
        ABORT = 1'b0;
        wait_idle(2000);
        n = dev.log_q.size();
        repeat (300) @(negedge CLK);
        chk_val({4'h0, DONE, FAIL, FAIL_CODE}, 8'h06);
        chk_val(8'(dev.log_q.size()), 8'(n));
        for (j = 0; j < n; j++) chk_frame(dev.log_q[j], tbl[j]);
        $display("abort test done");
    endtask

    initial begin
        void'($urandom(32'hc1ba_be39));
        tbl = '{24'h00_00bd, 24'h00_003c, 24'h00_1100, 24'h00_8000, 24'h00_8100,
            24'h01_2d8b, 24'h01_4601, 24'h02_a4ff, 24'h02_32ff, 24'h03_3301,
            24'h00_8762, 24'h00_88c9, 24'h00_890e, 24'h00_8a12, 24'h00_8d7b,
            24'h01_b000, 24'h01_b924, 24'h01_bc0d, 24'h01_be02, 24'h01_bf8e,
            24'h01_c02a, 24'h01_c12a, 24'h01_c47e, 24'h00_8b02, 24'h00_8c03,
            24'h00_8510, 24'h01_b509, 24'h01_bb13, 24'h01_c506, 24'h00_8310,
            24'h01_1201, 24'h01_1000};
        repeat (2) @(negedge CLK);
        RESETN = 1'b1;
        for (i = 0; i < 2; i++) run_seq($urandom_range(2, 0));
        abort_test();
        pulse_start();
        repeat (100) @(negedge CLK);
        RESETN = 1'b0;
        repeat (2) @(negedge CLK);
        chk_val({4'h0, SPI_CS_N, SPI_SCLK, BUSY, DONE}, 8'h08);
        RESETN = 1'b1;
        $display("mid-run reset test done");
        run_seq(99);
        wrap_up();
    end

    initial begin
        #(95000 * 40);
        n_mismatch++;
        $display("Error at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule

bind dac_startup_sequencer dac_startup_sequencer_assertions chk (.CLK(CLK),
    .RESETN(RESETN), .START(START), .ABORT(ABORT), .BUSY(BUSY), .DONE(DONE), .FAIL(FAIL),
    .FAIL_CODE(FAIL_CODE), .STEP(STEP), .ENTRY(ENTRY), .LOCK_TRIES(LOCK_TRIES),
    .LOCK_READ(LOCK_READ), .SPI_CS_N(SPI_CS_N), .SPI_SCLK(SPI_SCLK), .SPI_SDIO(SPI_SDIO),
    .SPI_SDO(SPI_SDO));
`default_nettype wire

// File: spi_device_model.sv
// behavioural converter register port for the start-up host bench
`timescale 1ns/1ps
`default_nettype none

module spi_device_model (
    // serial port
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic sdio,
    output logic sdo
);
    // ----
    // state
    // ----
    logic [7:0] regs [logic [14:0]];
    logic [23:0] log_q [$];
    logic [23:0] sh;
    logic [14:0] addr;
    logic [7:0] rbyte;
    logic rd;
    int cnt = 0;
    int n_reads = 0;
    int lock_after = 0;

    initial sdo = 1'b0;

    // lock shows only after the pll enable value is in place
    function automatic logic [7:0] read_reg(input logic [14:0] a);
        if (a == 15'h0084) begin
            return {7'h00, regs.exists(15'h0083) && regs[15'h0083] == 8'h10
                && n_reads >= lock_after};
        end
        return regs.exists(a) ? regs[a] : 8'h00;
    endfunction

    // ----
    // frame handling
    // ----
    always @(negedge cs_n) begin
        cnt = 0;
    end

    always @(posedge sclk) begin
        if (!cs_n) begin
            sh = {sh[22:0], sdio};
            cnt = cnt + 1;
            if (cnt == 16) begin
                rd = sh[15];
                addr = sh[14:0];
                rbyte = read_reg(sh[14:0]);
            end
        end
    end

    // no pull on the data-out line: it toggles whenever not driven
    always @(negedge sclk) begin
        if (!cs_n && rd && cnt >= 16 && cnt < 24) begin
            sdo = rbyte[23 - cnt];
        end else begin
            sdo = ~sdo;
        end
    end

    // a cut frame is dropped whole
    always @(posedge cs_n) begin
        sdo = ~sdo;
        if (cnt == 24 && rd) begin
            log_q.push_back({1'b1, addr, rbyte});
            n_reads = n_reads + ((addr == 15'h0084) ? 1 : 0);
        end else if (cnt == 24) begin
            if (addr == 15'h0000 && sh[7]) begin
                regs.delete();
            end
            if (addr != 15'h0084) begin
                regs[addr] = sh[7:0];
            end
            log_q.push_back({1'b0, addr, sh[7:0]});
        end
    end
endmodule
`default_nettype wire

// File: spi_frame.sv
// one 24-bit four-wire serial frame: r/w, 15-bit address, 8 data bits
`timescale 1ns/1ps
`default_nettype none

module spi_frame (
    input wire logic clk,
    input wire logic resetn,
    input wire logic tick,
    input wire logic req_valid,
    input wire startup_pkg::spi_req_t req,
    output logic req_ready,
    output logic done,
    output logic [7:0] rdata,
    output logic active,
    output logic cs_n,
    output logic sclk,
    output logic mosi,
    input wire logic miso_pin
);
    logic miso_meta;
    logic miso_s;
    logic [23:0] shift;
    logic [7:0] rx;
    logic [4:0] bits;
    logic next_cs_n, next_sclk, next_mosi, next_done;
    logic [23:0] next_shift;
    logic [7:0] next_rx;
    logic [7:0] next_rdata;
    logic [4:0] next_bits;

    // two flops before anything looks at the pin
    always_ff @(posedge clk) begin
        if (!resetn) begin
            miso_meta <= 1'b0;
            miso_s <= 1'b0;
        end else begin
            miso_meta <= miso_pin;
            miso_s <= miso_meta;
        end
    end

    assign req_ready = cs_n;
    assign active = !cs_n;

    // mode 0: device samples on rising edge; we sample late in the high phase
    always_comb begin
        next_cs_n = cs_n;
        next_sclk = sclk;
        next_mosi = mosi;
        next_shift = shift;
        next_rx = rx;
        next_rdata = rdata;
        next_bits = bits;
        next_done = 1'b0;
        if (cs_n) begin
            if (req_valid) begin
                next_cs_n = 1'b0;
                next_shift = {req.rd, req.addr, req.data};
                next_mosi = req.rd;
                next_bits = 5'h00;
            end
        end else if (tick) begin
            if (!sclk) begin
                next_sclk = 1'b1;
            end else begin
                next_sclk = 1'b0;
                next_rx = {rx[6:0], miso_s};
                next_shift = {shift[22:0], 1'b0};
                next_mosi = shift[22];
                next_bits = bits + 5'h01;
                if (bits == 5'(startup_pkg::FRAME_BITS - 1)) begin
                    next_cs_n = 1'b1;
                    next_mosi = 1'b0;
                    next_done = 1'b1;
                    next_rdata = {rx[6:0], miso_s};
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cs_n <= 1'b1;
            sclk <= 1'b0;
            mosi <= 1'b0;
            shift <= 24'h00_0000;
            rx <= 8'h00;
            rdata <= 8'h00;
            bits <= 5'h00;
            done <= 1'b0;
        end else begin
            cs_n <= next_cs_n;
            sclk <= next_sclk;
            mosi <= next_mosi;
            shift <= next_shift;
            rx <= next_rx;
            rdata <= next_rdata;
            bits <= next_bits;
            done <= next_done;
        end
    end
endmodule

`default_nettype wire

// File: startup_pkg.sv
// constants, types and start-up write list for the converter start-up host
package startup_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 40000;
    localparam int CS_GAP_NS = 100;
    localparam int CS_GAP_CYC = (CS_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int POLL_GAP_US = 100;
    localparam int POLL_GAP_CYC = (POLL_GAP_US * 1000000) / CLK_PERIOD_PS;
    localparam int SCLK_HALF_CYC = 4;
    localparam int POLL_LIMIT = 16;
    localparam int FRAME_BITS = 24;

    // ------------------------------------------------------------------
    // device registers
    // ------------------------------------------------------------------
    localparam logic [14:0] REG_RESET_AND_PORT_CONFIG = 15'h0000;
    localparam logic [14:0] REG_BLOCK_POWER_ENABLE = 15'h0011;
    localparam logic [14:0] REG_CLOCK_POWER_CONTROL = 15'h0080;
    localparam logic [14:0] REG_FRAME_REF_RECEIVER_CONTROL = 15'h0081;
    localparam logic [14:0] REG_PLL_ENABLE_CONTROL = 15'h0083;
    localparam logic [14:0] REG_PLL_LOCK_STATUS = 15'h0084;
    localparam logic [14:0] REG_PLL_FEEDBACK_DIVIDER = 15'h0085;
    localparam logic [14:0] REG_OSC_OUTPUT_DIVIDER = 15'h008b;
    localparam logic [14:0] REG_PLL_REFERENCE_DIVIDER = 15'h008c;
    localparam logic [14:0] REG_SAMPLE_FORMAT_SELECT = 15'h0110;
    localparam logic [14:0] REG_INTERPOLATION_SELECT = 15'h0112;
    localparam int LOCK_BIT = 0;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic [14:0] addr;
        logic [7:0] data;
    } spi_req_t;

    typedef struct packed {
        logic [14:0] addr;
        logic [7:0] data;
    } seq_entry_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_ISSUE = 7'b000_0010,
        ST_XFER = 7'b000_0100,
        ST_GAP = 7'b000_1000,
        ST_POLL_WAIT = 7'b001_0000,
        ST_DONE = 7'b010_0000,
        ST_FAIL = 7'b100_0000
    } seq_state_t;

    // ------------------------------------------------------------------
    // write list: clock step up to PLL enable, then datapath step
    // ------------------------------------------------------------------
    // stops before the link steps; the quick link setup is not deterministic
    localparam int SEQ_LEN = 32;
    localparam int LOCK_AFTER = 29;
    localparam logic [4:0] LOCK_AFTER_IDX = 5'h1d;
    localparam logic [4:0] LAST_IDX = 5'h1f;
    localparam seq_entry_t SEQ [SEQ_LEN] = '{
        '{REG_RESET_AND_PORT_CONFIG, 8'hbd},
        '{REG_RESET_AND_PORT_CONFIG, 8'h3c},
        '{REG_BLOCK_POWER_ENABLE, 8'h00},
        '{REG_CLOCK_POWER_CONTROL, 8'h00},
        '{REG_FRAME_REF_RECEIVER_CONTROL, 8'h00},
        '{15'h012d, 8'h8b}, '{15'h0146, 8'h01}, '{15'h02a4, 8'hff},
        '{15'h0232, 8'hff}, '{15'h0333, 8'h01},
        '{15'h0087, 8'h62}, '{15'h0088, 8'hc9}, '{15'h0089, 8'h0e},
        '{15'h008a, 8'h12}, '{15'h008d, 8'h7b}, '{15'h01b0, 8'h00},
        '{15'h01b9, 8'h24}, '{15'h01bc, 8'h0d}, '{15'h01be, 8'h02},
        '{15'h01bf, 8'h8e}, '{15'h01c0, 8'h2a}, '{15'h01c1, 8'h2a},
        '{15'h01c4, 8'h7e},
        '{REG_OSC_OUTPUT_DIVIDER, 8'h02},
        '{REG_PLL_REFERENCE_DIVIDER, 8'h03},
        '{REG_PLL_FEEDBACK_DIVIDER, 8'h10},
        '{15'h01b5, 8'h09}, '{15'h01bb, 8'h13}, '{15'h01c5, 8'h06},
        '{REG_PLL_ENABLE_CONTROL, 8'h10},
        '{REG_INTERPOLATION_SELECT, 8'h01},
        '{REG_SAMPLE_FORMAT_SELECT, 8'h00}
    };

endpackage

// File: tick_divider.sv
// half-period enable pulse generator for the serial clock
`timescale 1ns/1ps
`default_nettype none

module tick_divider #(
    parameter int DIV = 4
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic run,
    output logic tick
);
    logic [7:0] count;
    logic [7:0] next_count;

    // restarts when idle so the first half period is always full
    always_comb begin
        next_count = count + 8'h01;
        if (!run || count == 8'(DIV - 1)) begin
            next_count = 8'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            count <= 8'h00;
        end else begin
            count <= next_count;
        end
    end

    assign tick = run && (count == 8'(DIV - 1));
endmodule

`default_nettype wire
